/* File: hw/rmpu_pkg.sv */
// Purpose: shared constants and types of the region protection unit
// Assumes: 32-bit apb register bus, 32-bit core addresses
// Notes:   register map and permission encodings live here
package rmpu_pkg;

	localparam int          RMPU_NREG      = 8;
	localparam int          RMPU_IDXW      = 3;

	// ------------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [11:0] RMPU_A_CTRL    = 12'h000;
	localparam logic [11:0] RMPU_A_STAT    = 12'h004;
	localparam logic [11:0] RMPU_A_MASK    = 12'h008;
	localparam logic [11:0] RMPU_A_FADDR   = 12'h00c;
	localparam logic [11:0] RMPU_A_RBASE   = 12'h040;
	localparam logic [11:0] RMPU_A_RLIMIT  = 12'h060;
	localparam logic [11:0] RMPU_A_RATTR   = 12'h080;
	localparam logic [11:0] RMPU_A_ESPAN   = 12'h020;

	// attribute word fields
	localparam int          RMPU_F_EN      = 0;
	localparam int          RMPU_F_XEN     = 1;
	localparam int          RMPU_F_PERM_LO = 4;
	localparam int          RMPU_F_PERM_HI = 6;
	// ctrl register fields
	localparam int          RMPU_F_ON      = 0;
	localparam int          RMPU_F_BKG     = 1;
	// status bits
	localparam int          RMPU_S_ACC     = 0;
	localparam int          RMPU_S_CFG     = 1;
	localparam int          RMPU_NSTAT     = 2;

	localparam logic [31:0] RMPU_CTRL_RST  = 32'h0000_0003;
	localparam logic [31:0] RMPU_ATTR_RST  = 32'h0000_0000;
	localparam logic [31:0] RMPU_ADDR_RST  = 32'h0000_0000;

	// permission codes: privileged / user
	typedef enum logic [2:0] {
		RMPU_P_NONE   = 3'h0, // none / none
		RMPU_P_PRW    = 3'h1, // rw / none
		RMPU_P_PRW_UR = 3'h2, // rw / ro
		RMPU_P_FULL   = 3'h3, // rw / rw
		RMPU_P_PR     = 3'h5, // ro / none
		RMPU_P_PR_UR  = 3'h6  // ro / ro
	} rmpu_perm_t;

	typedef enum logic [1:0] {
		RMPU_OP_READ  = 2'h0,
		RMPU_OP_WRITE = 2'h1,
		RMPU_OP_FETCH = 2'h2
	} rmpu_op_t;

	typedef struct packed {
		logic [31:0] addr;
		rmpu_op_t    op;
		logic        priv;
	} rmpu_req_t;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] limit;
		logic        en;
		logic        xen;
		logic [2:0]  perm;
	} rmpu_region_t;

endpackage : rmpu_pkg

/* File: hw/rmpu_check.sv */
// Purpose: combinational permission check of one access
// Assumes: region table stable while evaluated
// Notes:   highest enabled matching index wins
`timescale 1ns/1ps
module rmpu_check
	import rmpu_pkg::*;
(
	input  wire rmpu_req_t                   req,
	input  wire rmpu_region_t [RMPU_NREG-1:0] regs,
	input  wire logic                        bkg_en,
	output logic                             allow
);

	// ------------------------------------------------------------------
	// permission decode
	// ------------------------------------------------------------------
	function automatic logic perm_ok(input logic [2:0] p, input logic pv,
		input rmpu_op_t op);
		logic rd;
		logic wr;
		rd = 1'b0;
		wr = 1'b0;
		case (p)
			RMPU_P_PRW:    begin rd = pv; wr = pv; end
			RMPU_P_PRW_UR: begin rd = 1'b1; wr = pv; end
			RMPU_P_FULL:   begin rd = 1'b1; wr = 1'b1; end
			RMPU_P_PR:     begin rd = pv; end
			RMPU_P_PR_UR:  begin rd = 1'b1; end
			default:       begin rd = 1'b0; end
		endcase
		return (op == RMPU_OP_WRITE) ? wr : rd;
	endfunction : perm_ok

	always_comb begin
		logic hit;
		hit   = 1'b0;
		allow = 1'b0;
		for (int i = 0; i < RMPU_NREG; i++) begin
			if (regs[i].en && req.addr >= regs[i].base &&
				req.addr <= regs[i].limit) begin
				hit   = 1'b1;
				allow = perm_ok(regs[i].perm, req.priv, req.op) &&
					(req.op != RMPU_OP_FETCH || regs[i].xen);
			end
		end
		if (!hit) begin
			allow = req.priv && bkg_en;
		end
	end

endmodule : rmpu_check

/* File: hw/rmpu_irq.sv */
// Purpose: sticky fault status, mask and interrupt line
// Assumes: w1c clear from the bus, set wins over clear
// Notes:   level interrupt output
`timescale 1ns/1ps
module rmpu_irq
	import rmpu_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	input  wire logic                  clk_en,
	input  wire logic [RMPU_NSTAT-1:0] set_ev,
	input  wire logic [RMPU_NSTAT-1:0] clr_w1c,
	input  wire logic                  mask_we,
	input  wire logic [RMPU_NSTAT-1:0] mask_wd,
	output logic      [RMPU_NSTAT-1:0] stat,
	output logic      [RMPU_NSTAT-1:0] mask,
	output logic                       irq
);

	logic [RMPU_NSTAT-1:0] stat_ff;
	logic [RMPU_NSTAT-1:0] nxt_stat;
	logic [RMPU_NSTAT-1:0] mask_ff;
	logic [RMPU_NSTAT-1:0] nxt_mask;

	always_comb begin
		nxt_stat = (stat_ff & ~clr_w1c) | set_ev;
		nxt_mask = mask_we ? mask_wd : mask_ff;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_ff <= '0;
			mask_ff <= '0;
		end else if (clk_en) begin
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
		end
	end

	assign stat = stat_ff;
	assign mask = mask_ff;
	assign irq  = |(stat_ff & mask_ff);

endmodule : rmpu_irq

/* File: hw/rmpu_top.sv */
// Purpose: region memory protection unit with apb configuration port
// Assumes: core holds an access request until it is answered
// Notes:   grant is combinational so a denied access never completes
`timescale 1ns/1ps
// How it works
// - every read, write and fetch of the core is checked.
// - privileged and user level are told apart by a request bit.
// - eight regions plus a privileged-only background region exist.
// - privileged software may use regions that user software may use.
// - user software is refused privileged-only regions.
// - where regions overlap the highest index decides.
// - each region has a fetch enable; fetches from it otherwise fail.
// - the no-access code faults all; privileged-rw faults user access.
// - rw/read-only code faults user writes; full code allows all.
// - the two read-only codes refuse every write.
// - the check is applied before and while the access stands.
// - after reset the attributes hold fixed default values.
// - user level bus writes never replace the configuration.
// - only privileged software changes configuration; it reads it too.
module rmpu_top
	import rmpu_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [2:0]  pprot,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        acc_valid,
	input  wire logic [31:0] acc_addr,
	input  wire logic [1:0]  acc_op,
	input  wire logic        acc_priv,
	output logic             acc_grant,
	output logic             acc_fault,
	output logic             irq
);

	// ------------------------------------------------------------------
	// configuration state
	// ------------------------------------------------------------------
	rmpu_region_t [RMPU_NREG-1:0] reg_ff;
	rmpu_region_t [RMPU_NREG-1:0] nxt_reg;
	logic [31:0]                  ctrl_ff;
	logic [31:0]                  nxt_ctrl;
	logic [31:0]                  faddr_ff;
	logic [31:0]                  nxt_faddr;
	logic [31:0]                  prdata_ff;
	logic [31:0]                  nxt_prdata;
	logic                         perr_ff;
	logic                         nxt_perr;

	rmpu_req_t                    req;
	logic                         allow;
	logic                         prot_on;
	logic                         bus_acc;
	logic                         bus_priv;
	logic                         cfg_deny;
	logic                         dec_hit;
	logic [RMPU_NSTAT-1:0]        stat;
	logic [RMPU_NSTAT-1:0]        mask;
	logic [RMPU_NSTAT-1:0]        set_ev;
	logic [RMPU_NSTAT-1:0]        clr_w1c;
	logic                         mask_we;

	// region slot of a table address, or no hit
	function automatic logic tbl_hit(input logic [11:0] a,
		input logic [11:0] b);
		return (a >= b) && (a < b + RMPU_A_ESPAN) && (a[1:0] == 2'h0);
	endfunction : tbl_hit

	function automatic logic [RMPU_IDXW-1:0] tbl_idx(input logic [11:0] a,
		input logic [11:0] b);
		logic [11:0] d;
		d = a - b;
		return d[RMPU_IDXW+1:2];
	endfunction : tbl_idx

	// ------------------------------------------------------------------
	// access check
	// ------------------------------------------------------------------
	assign prot_on = ctrl_ff[RMPU_F_ON];
	assign req     = '{addr: acc_addr, op: rmpu_op_t'(acc_op),
		priv: acc_priv};

	rmpu_check u_check (
		.req    (req),
		.regs   (reg_ff),
		.bkg_en (ctrl_ff[RMPU_F_BKG]),
		.allow  (allow)
	);

	// grant held low for the whole access whenever denied
	always_comb begin
		acc_grant = acc_valid && (allow || !prot_on);
		acc_fault = acc_valid && prot_on && !allow;
	end

	// ------------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------------
	assign bus_acc  = psel && penable;
	assign bus_priv = pprot[0];
	assign cfg_deny = bus_acc && pwrite && !bus_priv;
	assign pready   = 1'b1;
	assign pslverr  = perr_ff;
	assign prdata   = prdata_ff;

	always_comb begin
		dec_hit = (paddr == RMPU_A_CTRL) || (paddr == RMPU_A_STAT) ||
			(paddr == RMPU_A_MASK) || (paddr == RMPU_A_FADDR) ||
			tbl_hit(paddr, RMPU_A_RBASE) ||
			tbl_hit(paddr, RMPU_A_RLIMIT) ||
			tbl_hit(paddr, RMPU_A_RATTR);
	end

	// slverr of the setup cycle lines up with the access edge
	always_comb begin
		nxt_reg    = reg_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_faddr  = faddr_ff;
		nxt_prdata = 32'h0000_0000;
		nxt_perr   = 1'b0;
		clr_w1c    = '0;
		mask_we    = 1'b0;
		if (psel && !penable) begin
			nxt_perr = !dec_hit || (pwrite && !bus_priv);
			if (!pwrite && dec_hit && bus_priv) begin
				if (paddr == RMPU_A_CTRL) begin
					nxt_prdata = ctrl_ff;
				end else if (paddr == RMPU_A_STAT) begin
					nxt_prdata = {{(32-RMPU_NSTAT){1'b0}}, stat};
				end else if (paddr == RMPU_A_MASK) begin
					nxt_prdata = {{(32-RMPU_NSTAT){1'b0}}, mask};
				end else if (paddr == RMPU_A_FADDR) begin
					nxt_prdata = faddr_ff;
				end else if (tbl_hit(paddr, RMPU_A_RBASE)) begin
					nxt_prdata = reg_ff[tbl_idx(paddr, RMPU_A_RBASE)].base;
				end else if (tbl_hit(paddr, RMPU_A_RLIMIT)) begin
					nxt_prdata = reg_ff[tbl_idx(paddr, RMPU_A_RLIMIT)].limit;
				end else begin
					nxt_prdata = 32'h0000_0000;
					nxt_prdata[RMPU_F_EN] =
						reg_ff[tbl_idx(paddr, RMPU_A_RATTR)].en;
					nxt_prdata[RMPU_F_XEN] =
						reg_ff[tbl_idx(paddr, RMPU_A_RATTR)].xen;
					nxt_prdata[RMPU_F_PERM_HI:RMPU_F_PERM_LO] =
						reg_ff[tbl_idx(paddr, RMPU_A_RATTR)].perm;
				end
			end
		end
		if (bus_acc && pwrite && bus_priv) begin
			if (paddr == RMPU_A_CTRL) begin
				nxt_ctrl = pwdata;
			end else if (paddr == RMPU_A_STAT) begin
				clr_w1c = pwdata[RMPU_NSTAT-1:0];
			end else if (paddr == RMPU_A_MASK) begin
				mask_we = 1'b1;
			end else if (tbl_hit(paddr, RMPU_A_RBASE)) begin
				nxt_reg[tbl_idx(paddr, RMPU_A_RBASE)].base = pwdata;
			end else if (tbl_hit(paddr, RMPU_A_RLIMIT)) begin
				nxt_reg[tbl_idx(paddr, RMPU_A_RLIMIT)].limit = pwdata;
			end else if (tbl_hit(paddr, RMPU_A_RATTR)) begin
				nxt_reg[tbl_idx(paddr, RMPU_A_RATTR)].en =
					pwdata[RMPU_F_EN];
				nxt_reg[tbl_idx(paddr, RMPU_A_RATTR)].xen =
					pwdata[RMPU_F_XEN];
				nxt_reg[tbl_idx(paddr, RMPU_A_RATTR)].perm =
					pwdata[RMPU_F_PERM_HI:RMPU_F_PERM_LO];
			end
		end
		if (acc_fault) begin
			nxt_faddr = acc_addr;
		end
		set_ev = '0;
		set_ev[RMPU_S_ACC] = acc_fault;
		set_ev[RMPU_S_CFG] = cfg_deny;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < RMPU_NREG; i++) begin
				reg_ff[i].base  <= RMPU_ADDR_RST;
				reg_ff[i].limit <= RMPU_ADDR_RST;
				reg_ff[i].en    <= RMPU_ATTR_RST[RMPU_F_EN];
				reg_ff[i].xen   <= RMPU_ATTR_RST[RMPU_F_XEN];
				reg_ff[i].perm  <= RMPU_ATTR_RST[RMPU_F_PERM_HI:RMPU_F_PERM_LO];
			end
			ctrl_ff   <= RMPU_CTRL_RST;
			faddr_ff  <= RMPU_ADDR_RST;
			prdata_ff <= 32'h0000_0000;
			perr_ff   <= 1'b0;
		end else if (clk_en) begin
			reg_ff    <= nxt_reg;
			ctrl_ff   <= nxt_ctrl;
			faddr_ff  <= nxt_faddr;
			prdata_ff <= nxt_prdata;
			perr_ff   <= nxt_perr;
		end
	end

	rmpu_irq u_irq (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.set_ev  (set_ev),
		.clr_w1c (clr_w1c),
		.mask_we (mask_we),
		.mask_wd (pwdata[RMPU_NSTAT-1:0]),
		.stat    (stat),
		.mask    (mask),
		.irq     (irq)
	);

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	// winning region picked apart from the checker, for the checks below
	logic                 chk_hit;
	logic [RMPU_IDXW-1:0] chk_idx;

	always_comb begin
		chk_hit = 1'b0;
		chk_idx = '0;
		for (int i = 0; i < RMPU_NREG; i++) begin
			if (reg_ff[i].en && acc_addr >= reg_ff[i].base &&
				acc_addr <= reg_ff[i].limit) begin
				chk_hit = 1'b1;
				chk_idx = RMPU_IDXW'(i);
			end
		end
	end

	user_cfg_block_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		clk_en && cfg_deny |=> $stable(ctrl_ff) && $stable(reg_ff))
		else $error("user write changed configuration");

	user_cfg_flag_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		clk_en && cfg_deny |=> stat[RMPU_S_CFG])
		else $error("user config write not flagged");

	no_grant_fault_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		!(acc_grant && acc_fault))
		else $error("grant and fault together");

	user_bkg_fault_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		acc_valid && prot_on && !acc_priv &&
		!(|{reg_ff[7].en, reg_ff[6].en, reg_ff[5].en, reg_ff[4].en,
		reg_ff[3].en, reg_ff[2].en, reg_ff[1].en, reg_ff[0].en})
		|-> acc_fault)
		else $error("user access without region granted");

	top_prio_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		acc_valid && prot_on && reg_ff[7].en &&
		acc_addr >= reg_ff[7].base && acc_addr <= reg_ff[7].limit &&
		reg_ff[7].perm == RMPU_P_NONE |-> acc_fault)
		else $error("region 7 did not win");

	fault_stat_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		clk_en && acc_fault |=> stat[RMPU_S_ACC] &&
		faddr_ff == $past(acc_addr))
		else $error("fault not recorded");

	full_allow_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		acc_valid && prot_on && acc_op != RMPU_OP_FETCH && reg_ff[7].en &&
		acc_addr >= reg_ff[7].base && acc_addr <= reg_ff[7].limit &&
		reg_ff[7].perm == RMPU_P_FULL |-> acc_grant)
		else $error("full access refused");

	irq_level_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		irq == |(stat & mask))
		else $error("interrupt level wrong");

	user_priv_only_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		acc_valid && prot_on && !acc_priv && chk_hit &&
		reg_ff[chk_idx].perm inside {RMPU_P_NONE, RMPU_P_PRW, RMPU_P_PR}
		|-> acc_fault)
		else $error("user access to privileged region granted");

	priv_user_ok_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		acc_valid && prot_on && acc_priv && chk_hit &&
		acc_op == RMPU_OP_READ && reg_ff[chk_idx].perm inside
		{RMPU_P_PRW_UR, RMPU_P_FULL, RMPU_P_PR_UR} |-> acc_grant)
		else $error("privileged read of user region refused");

	fetch_off_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		acc_valid && prot_on && chk_hit && acc_op == RMPU_OP_FETCH &&
		!reg_ff[chk_idx].xen |-> acc_fault)
		else $error("fetch from fetch-disabled region granted");

	none_code_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		acc_valid && prot_on && chk_hit &&
		(reg_ff[chk_idx].perm == RMPU_P_NONE ||
		(reg_ff[chk_idx].perm == RMPU_P_PRW && !acc_priv)) |-> acc_fault)
		else $error("no-access code granted");

	ro_write_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		acc_valid && prot_on && chk_hit && acc_op == RMPU_OP_WRITE &&
		reg_ff[chk_idx].perm inside {RMPU_P_PR, RMPU_P_PR_UR} |-> acc_fault)
		else $error("write to read-only region granted");

	frozen_state_a: assert property (@(posedge sys_clk)
		disable iff (!rst_b)
		!clk_en |=> $stable(ctrl_ff) && $stable(reg_ff) &&
		$stable(faddr_ff) && $stable(stat))
		else $error("state moved while clock enable low");

endmodule : rmpu_top

/* File: test/rmpu_core_model.sv */
// Purpose: core side model issuing checked code and data accesses
// Assumes: request held until the answer edge
// Notes:   released address and privilege lines show inverted stale values
`timescale 1ns/1ps
module rmpu_core_model
	import rmpu_pkg::*;
(
	input  wire logic        sys_clk,
	output logic             acc_valid,
	output logic      [31:0] acc_addr,
	output logic      [1:0]  acc_op,
	output logic             acc_priv,
	input  wire logic        acc_grant,
	input  wire logic        acc_fault
);
	logic [1:0] seen;

	initial begin
		acc_valid = 1'b0;
		acc_addr  = 32'h0000_0000;
		acc_op    = 2'h0;
		acc_priv  = 1'b0;
		seen      = 2'h0;
	end

	// hold > 1 plays a slow core keeping the request standing
	task automatic access(input logic [31:0] a, input rmpu_op_t op,
		input logic pv, input int hold);
		@(posedge sys_clk);
		acc_valid <= 1'b1;
		acc_addr  <= a;
		acc_op    <= op;
		acc_priv  <= pv;
		repeat (hold) @(posedge sys_clk);
		seen = {acc_grant, acc_fault};
		acc_valid <= 1'b0;
		// stale address must not look valid once released
		acc_addr  <= ~a;
		acc_priv  <= ~pv;
	endtask : access
endmodule : rmpu_core_model

/* File: test/tb_rmpu_top.sv */
// Purpose: self-checking bench of the region protection unit
// Assumes: zero wait apb slave, combinational grant
// Notes:   region 0 spans 0x1000..0x1fff in the permission sweep
`timescale 1ns/1ps
module tb_rmpu_top
	import rmpu_pkg::*;
;
	logic        sys_clk, rst_b, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  pprot;
	logic        pready, pslverr, err, irq;
	logic        clk_en;
	logic        acc_valid, acc_priv, acc_grant, acc_fault;
	logic [31:0] acc_addr;
	logic [1:0]  acc_op;
	int          fail_count, checked;
	int          codes [8] = '{0, 1, 2, 3, 4, 5, 6, 7};

	rmpu_top u_rmpu_top (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pprot(pprot), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr),
		.acc_op(acc_op), .acc_priv(acc_priv), .acc_grant(acc_grant),
		.acc_fault(acc_fault), .irq(irq));
	rmpu_core_model u_rmpu_core_model (.sys_clk(sys_clk),
		.acc_valid(acc_valid), .acc_addr(acc_addr), .acc_op(acc_op),
		.acc_priv(acc_priv), .acc_grant(acc_grant), .acc_fault(acc_fault));

	always #2.5 sys_clk = ~sys_clk;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic pr);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pprot   <= {2'b00, pr};
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b1);
	endtask : wr

	task automatic rdc(input string n, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 1'b1);
		chk(n, rd, e);
	endtask : rdc

	task automatic acc(input logic [31:0] a, input rmpu_op_t op,
		input logic pv, input logic eg);
		u_rmpu_core_model.access(a, op, pv, 2);
		chk("acc_grant", {31'h0, u_rmpu_core_model.seen[1]}, {31'h0, eg});
		chk("acc_fault", {31'h0, u_rmpu_core_model.seen[0]}, {31'h0, !eg});
	endtask : acc

	task automatic region(input int i, input logic [31:0] b,
		input logic [31:0] l, input logic [31:0] at);
		wr(RMPU_A_RBASE + 12'(4 * i), b);
		wr(RMPU_A_RLIMIT + 12'(4 * i), l);
		wr(RMPU_A_RATTR + 12'(4 * i), at);
	endtask : region

	function automatic logic ok(input int p, input logic pv,
		input rmpu_op_t op);
		if (op == RMPU_OP_WRITE)
			return pv ? (p inside {1, 2, 3}) : (p == 3);
		return pv ? (p inside {1, 2, 3, 5, 6}) : (p inside {2, 3, 6});
	endfunction : ok

	task automatic results();
		if (fail_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		rdc("ctrl", RMPU_A_CTRL, RMPU_CTRL_RST);
		rdc("mask", RMPU_A_MASK, 32'h0000_0000);
		rdc("stat", RMPU_A_STAT, 32'h0000_0000);
		rdc("rattr7", RMPU_A_RATTR + 12'h01c, RMPU_ATTR_RST);
		acc(32'h0000_0100, RMPU_OP_READ, 1'b1, 1'b1);
		acc(32'h0000_0100, RMPU_OP_READ, 1'b0, 1'b0);
		wr(RMPU_A_STAT, 32'h0000_0003);
	endtask : t_reset

	task automatic t_user_cfg();
		apb(1'b1, RMPU_A_RATTR, 32'h0000_0033, 1'b0);
		chk("pslverr", {31'h0, err}, 32'h1);
		rdc("rattr0", RMPU_A_RATTR, 32'h0000_0000);
		rdc("stat", RMPU_A_STAT, 32'h0000_0002);
		apb(1'b0, RMPU_A_CTRL, 32'h0000_0000, 1'b0);
		chk("user read", rd, 32'h0000_0000);
		apb(1'b0, 12'h3fc, 32'h0000_0000, 1'b1);
		chk("unmapped", {31'h0, err}, 32'h1);
		wr(RMPU_A_STAT, 32'h0000_0003);
	endtask : t_user_cfg

	task automatic t_perm();
		region(0, 32'h0000_1000, 32'h0000_1fff, 32'h0000_0003);
		rdc("rlimit0", RMPU_A_RLIMIT, 32'h0000_1fff);
		foreach (codes[k]) begin
			wr(RMPU_A_RATTR, 32'(codes[k] << 4) | 32'h3);
			for (int pv = 0; pv < 2; pv++) begin
				for (int o = 0; o < 3; o++) begin
					acc(32'h0000_1800, rmpu_op_t'(o), pv[0],
						ok(codes[k], pv[0], rmpu_op_t'(o)));
				end
			end
		end
	endtask : t_perm

	task automatic t_fetch_overlap();
		wr(RMPU_A_RATTR, 32'h0000_0031);
		acc(32'h0000_1000, RMPU_OP_FETCH, 1'b1, 1'b0);
		acc(32'h0000_1000, RMPU_OP_READ, 1'b1, 1'b1);
		region(7, 32'h0000_1800, 32'h0000_18ff, 32'h0000_0001);
		acc(32'h0000_1810, RMPU_OP_READ, 1'b1, 1'b0);
		wr(RMPU_A_RATTR, 32'h0000_0001);
		wr(RMPU_A_RATTR + 12'h01c, 32'h0000_0033);
		acc(32'h0000_1810, RMPU_OP_WRITE, 1'b0, 1'b1);
		acc(32'h0000_1810, RMPU_OP_FETCH, 1'b0, 1'b1);
	endtask : t_fetch_overlap

	task automatic t_irq();
		wr(RMPU_A_STAT, 32'h0000_0003);
		wr(RMPU_A_MASK, 32'h0000_0001);
		acc(32'h0000_1000, RMPU_OP_WRITE, 1'b0, 1'b0);
		repeat (2) @(posedge sys_clk);
		chk("irq", {31'h0, irq}, 32'h1);
		rdc("faddr", RMPU_A_FADDR, 32'h0000_1000);
		wr(RMPU_A_STAT, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		chk("irq clr", {31'h0, irq}, 32'h0);
		wr(RMPU_A_MASK, 32'h0000_0000);
		wr(RMPU_A_CTRL, 32'h0000_0001);
		acc(32'h0000_0100, RMPU_OP_READ, 1'b1, 1'b0);
		repeat (2) @(posedge sys_clk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rdc("stat", RMPU_A_STAT, 32'h0000_0001);
		wr(RMPU_A_CTRL, 32'h0000_0000);
		acc(32'h0000_1000, RMPU_OP_WRITE, 1'b0, 1'b1);
	endtask : t_irq

	// a fault seen while the clock enable is low must leave no trace
	task automatic t_freeze();
		wr(RMPU_A_CTRL, RMPU_CTRL_RST);
		wr(RMPU_A_STAT, 32'h0000_0003);
		@(posedge sys_clk);
		clk_en <= 1'b0;
		acc(32'h0000_0200, RMPU_OP_READ, 1'b0, 1'b0);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		rdc("stat frozen", RMPU_A_STAT, 32'h0000_0000);
		rdc("faddr frozen", RMPU_A_FADDR, 32'h0000_0100);
	endtask : t_freeze

	initial begin
		sys_clk = 1'b0;
		rst_b = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pprot = 3'h1;
		clk_en = 1'b1;
		fail_count = 0;
		checked = 0;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset();
		t_user_cfg();
		t_perm();
		t_fetch_overlap();
		t_irq();
		t_freeze();
		results();
	end

	// whole run is well under 2000 cycles
	initial begin
		#20000;
		fail_count++;
		results();
	end
endmodule : tb_rmpu_top
